// >>> hdl/irq_logic_cfg.svh
// Purpose: offsets, field positions, reset values and counts of the irq logic
// Assumes: included by bare name, definitions only
// Notes: register index equals the byte offset on the plain register port
`ifndef IRQ_LOGIC_CFG_SVH
`define IRQ_LOGIC_CFG_SVH
// register offsets
`define OFS_IRQ_CONTROL 4'h0
`define OFS_PERIPH_FLAGS_ONE 4'h1
`define OFS_PERIPH_FLAGS_TWO 4'h2
`define OFS_PERIPH_ENABLES_ONE 4'h3
`define OFS_PERIPH_ENABLES_TWO 4'h4
`define OFS_PIN_MASK 4'h5
`define OFS_SYS_STATUS 4'h6
`define OFS_SYS_ENABLE 4'h7
`define OFS_SYS_CLEAR 4'h8
// interrupt control field positions
`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_EN 6
// reset values
`define RST_IRQ_CONTROL 8'h00
`define RST_PERIPH 8'h00
`define RST_PIN_MASK 8'h00
// implemented bits of the second flag and enable registers
`define MASK_PERIPH_TWO 8'hF5
// system status bit positions
`define SYS_BIT_TAKEN 0
`define SYS_BIT_RACE 1
// timing
`define TIME_INSTR_CYCLE_NS 40
`define TIME_CLK_NS 10
`define QUARTERS_PER_INSTR (`TIME_INSTR_CYCLE_NS / `TIME_CLK_NS)
`define SYNC_LATENCY_INSTR 2'h3
`define VECTOR_ADDR 13'h0004
`endif

// >>> hdl/irq_logic_pkg.sv
// Purpose: types shared by the irq logic
// Assumes: nothing
// Notes: quarter phases follow the instruction cycle
package irq_logic_pkg;
  typedef enum logic [1:0] {
    QP_Q1 = 2'b00,
    QP_Q2 = 2'b01,
    QP_Q3 = 2'b10,
    QP_Q4 = 2'b11
  } quarter_t;
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_COUNT = 1'b1
  } seq_state_t;
endpackage

// >>> hdl/irq_logic.sv
// Purpose: interrupt request logic of a small microcontroller core
// Assumes: event inputs are one-cycle pulses from same-clock peripherals
// Notes: pins of the io port and the external pin are synchronised first
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ns
`include "irq_logic_cfg.svh"
module irq_logic
  import irq_logic_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int PC_W = 13
) (
  input wire logic CLK_SYS_IN, // system clock
  input wire logic NRST_IN, // synchronous reset, low
  input wire logic [3:0] ADDR_IN, // register address
  input wire logic [7:0] WDATA_IN, // register write data
  input wire logic WR_IN, // write strobe
  input wire logic RD_IN, // read strobe
  output logic [7:0] RDATA_OUT, // read data, cycle after strobe
  input wire logic [PORT_W-1:0] PORT_PINS_IN, // second io port pins, async
  input wire logic PORT_READ_IN, // core reads the port
  input wire logic EXT_PIN_IN, // external interrupt pin, async
  input wire logic EXT_EDGE_RISING_IN, // 1 rising edge, 0 falling edge
  input wire logic TIMER0_OVF_IN, // timer0 overflow pulse
  input wire logic [7:0] PERIPH_ONE_EV_IN, // first peripheral events
  input wire logic [7:0] PERIPH_TWO_EV_IN, // second peripheral events
  input wire logic RETURN_IRQ_IN, // return from irq executed
  input wire logic [PC_W-1:0] RETURN_PC_IN, // address to return to
  output logic [1:0] QUARTER_OUT, // current quarter phase
  output logic IRQ_REQ_OUT, // request to the core
  output logic STACK_PUSH_OUT, // push return address
  output logic [PC_W-1:0] STACK_DATA_OUT, // return address pushed
  output logic PC_LOAD_OUT, // load program counter
  output logic [PC_W-1:0] PC_VECTOR_OUT, // vector address
  output logic SYS_IRQ_OUT // enabled system status pending
);

  // registers
  quarter_t quarter_reg;
  quarter_t quarter_next;
  seq_state_t seq_reg;
  seq_state_t seq_next;
  logic [1:0] stage_reg;
  logic [1:0] stage_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] pflag1_reg;
  logic [7:0] pflag1_next;
  logic [7:0] pflag2_reg;
  logic [7:0] pflag2_next;
  logic [7:0] pen1_reg;
  logic [7:0] pen1_next;
  logic [7:0] pen2_reg;
  logic [7:0] pen2_next;
  logic [PORT_W-1:0] mask_reg;
  logic [PORT_W-1:0] mask_next;
  logic [PORT_W-1:0] pin_s1_reg;
  logic [PORT_W-1:0] pin_s2_reg;
  logic [PORT_W-1:0] ref_reg;
  logic [PORT_W-1:0] ref_next;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_s3_reg;
  logic ext_pend_reg;
  logic ext_pend_next;
  logic [1:0] sys_stat_reg;
  logic [1:0] sys_stat_next;
  logic [1:0] sys_en_reg;
  logic [1:0] sys_en_next;
  logic [7:0] rdata_next;
  // address decode
  wire wr_ctrl = WR_IN && (ADDR_IN == `OFS_IRQ_CONTROL);
  wire wr_pf1 = WR_IN && (ADDR_IN == `OFS_PERIPH_FLAGS_ONE);
  wire wr_pf2 = WR_IN && (ADDR_IN == `OFS_PERIPH_FLAGS_TWO);
  wire wr_pe1 = WR_IN && (ADDR_IN == `OFS_PERIPH_ENABLES_ONE);
  wire wr_pe2 = WR_IN && (ADDR_IN == `OFS_PERIPH_ENABLES_TWO);
  wire wr_mask = WR_IN && (ADDR_IN == `OFS_PIN_MASK);
  wire wr_sen = WR_IN && (ADDR_IN == `OFS_SYS_ENABLE);
  wire wr_sclr = WR_IN && (ADDR_IN == `OFS_SYS_CLEAR);

  // quarter phase sequencing
  wire in_q4 = (quarter_reg == QP_Q4);
  wire in_q1 = (quarter_reg == QP_Q1);
  wire in_q2 = (quarter_reg == QP_Q2);
  assign quarter_next = quarter_t'(quarter_reg + 2'h1);

  // external pin edge detect on the synchronised level
  wire ext_rise = ext_s2_reg && !ext_s3_reg;
  wire ext_fall = !ext_s2_reg && ext_s3_reg;
  wire ext_edge = EXT_EDGE_RISING_IN ? ext_rise : ext_fall;
  wire ext_window = in_q4 || in_q1;
  wire ext_set = (ext_edge || ext_pend_reg) && ext_window;
  assign ext_pend_next = (ext_edge || ext_pend_reg) && !ext_window;

  // port change detect against the value seen at the last read
  wire [PORT_W-1:0] pin_diff;
  // one masked compare per pin, so unwatched pins never raise the flag
  for (genvar gi = 0; gi < PORT_W; gi++) begin : g_pin_diff
    assign pin_diff[gi] = (pin_s2_reg[gi] ^ ref_reg[gi]) & mask_reg[gi];
  end
  wire port_read_now = PORT_READ_IN && in_q2;
  wire port_changed = |pin_diff;
  wire port_set = port_changed && !port_read_now;
  wire port_race = port_changed && port_read_now;
  assign ref_next = PORT_READ_IN ? pin_s2_reg : ref_reg;

  // request: global enable over enabled flags
  wire [2:0] ctrl_hits = ctrl_reg[5:3] & ctrl_reg[2:0];
  wire p1_hit = |(pflag1_reg & pen1_reg);
  wire p2_hit = |(pflag2_reg & pen2_reg);
  wire periph_hit = ctrl_reg[`BIT_PERIPH_EN] && (p1_hit || p2_hit);
  wire glob_en = ctrl_reg[`BIT_GLOBAL_EN];
  wire irq_req = glob_en && ((|ctrl_hits) || periph_hit);
  wire last_stage = (stage_reg == (`SYNC_LATENCY_INSTR - 2'h1));
  wire take = (seq_reg == SEQ_COUNT) && irq_req && in_q4 && last_stage;

  // latency counter counts instruction boundaries after the request
  always_comb begin
    seq_next = seq_reg;
    stage_next = stage_reg;
    case (seq_reg)
      SEQ_IDLE: begin
        if (irq_req) begin
          seq_next = SEQ_COUNT;
          stage_next = in_q4 ? 2'h1 : 2'h0;
        end
      end
      SEQ_COUNT: begin
        if (!irq_req) begin
          seq_next = SEQ_IDLE;
          stage_next = 2'h0;
        end else if (in_q4) begin
          if (last_stage) begin
            seq_next = SEQ_IDLE;
            stage_next = 2'h0;
          end else begin
            stage_next = stage_reg + 2'h1;
          end
        end
      end
      default: begin
        seq_next = SEQ_IDLE;
        stage_next = 2'h0;
      end
    endcase
  end

  // control register: write, then hardware sets win, then global enable
  always_comb begin
    ctrl_next = wr_ctrl ? WDATA_IN : ctrl_reg;
    ctrl_next[2] = ctrl_next[2] | TIMER0_OVF_IN;
    ctrl_next[1] = ctrl_next[1] | ext_set;
    ctrl_next[0] = ctrl_next[0] | port_set;
    if (RETURN_IRQ_IN) begin
      ctrl_next[`BIT_GLOBAL_EN] = 1'b1;
    end
    if (take) begin
      ctrl_next[`BIT_GLOBAL_EN] = 1'b0;
    end
  end

  // peripheral flags and enables; absent bits masked away
  assign pflag1_next = (wr_pf1 ? WDATA_IN : pflag1_reg) | PERIPH_ONE_EV_IN;
  assign pflag2_next = ((wr_pf2 ? WDATA_IN : pflag2_reg) | PERIPH_TWO_EV_IN)
    & `MASK_PERIPH_TWO;
  assign pen1_next = wr_pe1 ? WDATA_IN : pen1_reg;
  assign pen2_next = (wr_pe2 ? WDATA_IN : pen2_reg) & `MASK_PERIPH_TWO;
  assign mask_next = wr_mask ? WDATA_IN[PORT_W-1:0] : mask_reg;

  // system status: sticky events, write-one clear, set wins
  wire [1:0] sys_events = {port_race, take};
  wire [1:0] sys_clr = wr_sclr ? WDATA_IN[1:0] : 2'h0;
  assign sys_stat_next = (sys_stat_reg & ~sys_clr) | sys_events;
  assign sys_en_next = wr_sen ? WDATA_IN[1:0] : sys_en_reg;

  // read mux, zero on unmapped or write-only offsets
  always_comb begin
    rdata_next = 8'h00;
    if (RD_IN) begin
      case (ADDR_IN)
        `OFS_IRQ_CONTROL: rdata_next = ctrl_reg;
        `OFS_PERIPH_FLAGS_ONE: rdata_next = pflag1_reg;
        `OFS_PERIPH_FLAGS_TWO: rdata_next = pflag2_reg;
        `OFS_PERIPH_ENABLES_ONE: rdata_next = pen1_reg;
        `OFS_PERIPH_ENABLES_TWO: rdata_next = pen2_reg;
        `OFS_PIN_MASK: rdata_next = 8'(mask_reg);
        `OFS_SYS_STATUS: rdata_next = {6'h00, sys_stat_reg};
        `OFS_SYS_ENABLE: rdata_next = {6'h00, sys_en_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // two-stage synchronisers for the async pins
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg <= PORT_PINS_IN;
      pin_s2_reg <= pin_s1_reg;
      ext_s1_reg <= EXT_PIN_IN;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // phase and latency sequencer state
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      quarter_reg <= QP_Q1;
      seq_reg <= SEQ_IDLE;
      stage_reg <= 2'h0;
    end else begin
      quarter_reg <= quarter_next;
      seq_reg <= seq_next;
      stage_reg <= stage_next;
    end
  end

  // interrupt control register
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      ctrl_reg <= `RST_IRQ_CONTROL;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // first peripheral flag register
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      pflag1_reg <= `RST_PERIPH;
    end else begin
      pflag1_reg <= pflag1_next;
    end
  end

  // second peripheral flag register
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      pflag2_reg <= `RST_PERIPH;
    end else begin
      pflag2_reg <= pflag2_next;
    end
  end

  // first peripheral enable register
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      pen1_reg <= `RST_PERIPH;
    end else begin
      pen1_reg <= pen1_next;
    end
  end

  // second peripheral enable register
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      pen2_reg <= `RST_PERIPH;
    end else begin
      pen2_reg <= pen2_next;
    end
  end

  // port pin mask
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      mask_reg <= PORT_W'(`RST_PIN_MASK);
    end else begin
      mask_reg <= mask_next;
    end
  end

  // system status, sticky
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      sys_stat_reg <= 2'h0;
    end else begin
      sys_stat_reg <= sys_stat_next;
    end
  end

  // system enable
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      sys_en_reg <= 2'h0;
    end else begin
      sys_en_reg <= sys_en_next;
    end
  end

  // edge and port reference state
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      ext_pend_reg <= 1'b0;
      ref_reg <= '0;
    end else begin
      ext_pend_reg <= ext_pend_next;
      ref_reg <= ref_next;
    end
  end

  // read data, standing one cycle after the strobe
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      RDATA_OUT <= 8'h00;
    end else begin
      RDATA_OUT <= rdata_next;
    end
  end

  // quarter phase, in step with the internal phase
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      QUARTER_OUT <= 2'h0;
    end else begin
      QUARTER_OUT <= quarter_next;
    end
  end

  // request level to the core
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      IRQ_REQ_OUT <= 1'b0;
    end else begin
      IRQ_REQ_OUT <= irq_req;
    end
  end

  // system status interrupt level
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      SYS_IRQ_OUT <= 1'b0;
    end else begin
      SYS_IRQ_OUT <= |(sys_stat_next & sys_en_next);
    end
  end

  // vector load and push as one-cycle pulses
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      STACK_PUSH_OUT <= 1'b0;
      STACK_DATA_OUT <= '0;
      PC_LOAD_OUT <= 1'b0;
      PC_VECTOR_OUT <= '0;
    end else begin
      STACK_PUSH_OUT <= take;
      STACK_DATA_OUT <= take ? RETURN_PC_IN : STACK_DATA_OUT;
      PC_LOAD_OUT <= take;
      PC_VECTOR_OUT <= PC_W'(`VECTOR_ADDR);
    end
  end

endmodule

// >>> sim/irq_logic_monitor.sv
// Purpose: port checks of the irq logic
// Assumes: bound to irq_logic, one clock domain
// Notes: take must come two to three instruction cycles after request
`timescale 1ns/1ns
`include "irq_logic_cfg.svh"
module irq_logic_monitor #(
  parameter int PORT_W = 8,
  parameter int PC_W = 13
) (
  input wire logic CLK_SYS_IN, // clock
  input wire logic NRST_IN, // reset, low
  input wire logic [3:0] ADDR_IN, // address
  input wire logic RD_IN, // read strobe
  input wire logic [7:0] RDATA_OUT, // read data
  input wire logic [PC_W-1:0] RETURN_PC_IN, // return address
  input wire logic [1:0] QUARTER_OUT, // phase
  input wire logic IRQ_REQ_OUT, // request
  input wire logic STACK_PUSH_OUT, // push
  input wire logic [PC_W-1:0] STACK_DATA_OUT, // pushed address
  input wire logic PC_LOAD_OUT, // load
  input wire logic [PC_W-1:0] PC_VECTOR_OUT // vector
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);
  // request rises, then stands two instruction cycles
  sequence req_start;
    $rose(IRQ_REQ_OUT);
  endsequence
  sequence req_held;
    req_start ##1 IRQ_REQ_OUT [*8];
  endsequence
  chk_no_early: assert property (req_start |-> !PC_LOAD_OUT [*8])
    else $error("take too early");
  chk_take_due: assert property (req_held |-> ##[1:4] (PC_LOAD_OUT || !IRQ_REQ_OUT))
    else $error("take missing");
  chk_quarter_step: assert property ($past(NRST_IN) |-> QUARTER_OUT == $past(QUARTER_OUT) + 2'h1)
    else $error("quarter not stepping");
  chk_push_load: assert property (PC_LOAD_OUT == STACK_PUSH_OUT)
    else $error("push and load apart");
  chk_vector_addr: assert property (PC_LOAD_OUT |-> PC_VECTOR_OUT == `VECTOR_ADDR)
    else $error("wrong vector");
  chk_req_drops: assert property (PC_LOAD_OUT |=> !IRQ_REQ_OUT && !PC_LOAD_OUT)
    else $error("request stands after take");
  chk_saved_pc: assert property (STACK_PUSH_OUT |-> STACK_DATA_OUT == $past(RETURN_PC_IN))
    else $error("wrong return address");
  chk_take_cause: assert property (PC_LOAD_OUT |-> $past(IRQ_REQ_OUT))
    else $error("take without request");
  chk_absent_bits: assert property (RD_IN && (ADDR_IN == 4'h2 || ADDR_IN == 4'h4) |=>
    RDATA_OUT[3] == 1'b0 && RDATA_OUT[1] == 1'b0) else $error("absent bit set");
endmodule

// >>> sim/core_model.sv
// Purpose: behavioural core sequencer beside the irq logic
// Assumes: bench commands each return
// Notes: pc steps every clock it is not loaded or popped, only pc is stacked
`timescale 1ns/1ns
module core_model #(
  parameter int PC_W = 13
) (
  input wire logic clk_in, // clock
  input wire logic nrst_in, // reset, low
  input wire logic ret_cmd_in, // bench asks for a return
  input wire logic push_in, // push request
  input wire logic load_in, // load request
  input wire logic [PC_W-1:0] push_data_in, // pushed address
  input wire logic [PC_W-1:0] vector_in, // vector address
  output logic ret_out, // return executed
  output logic [PC_W-1:0] pc_out // program counter
);
  logic [PC_W-1:0] stack_reg [0:7];
  logic [2:0] sp_reg;
  // jump on load, pop on return, push the return address only
  always_ff @(posedge clk_in) begin
    ret_out <= ret_cmd_in;
    if (!nrst_in) begin
      pc_out <= '0;
      sp_reg <= 3'h0;
    end else if (load_in) begin
      pc_out <= vector_in;
    end else if (ret_cmd_in) begin
      pc_out <= stack_reg[sp_reg-3'h1];
      sp_reg <= sp_reg - 3'h1;
    end else begin
      pc_out <= pc_out + 1'b1;
    end
    if (push_in) begin
      stack_reg[sp_reg] <= push_data_in;
      sp_reg <= sp_reg + 3'h1;
    end
  end
endmodule

// >>> sim/testbench.sv
// Purpose: self-checking bench of the irq logic
// Assumes: core model answers pushes and returns
// Notes: port reads and both external edge modes are exercised
`timescale 1ns/1ns
`include "irq_logic_cfg.svh"
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] pins = 8'h00;
  logic ext = 1'b0;
  logic prd = 1'b0;
  logic esel = 1'b1;
  logic t0 = 1'b0;
  logic [7:0] ev1 = 8'h00;
  logic [7:0] ev2 = 8'h00;
  logic ret_cmd = 1'b0;
  logic ret;
  logic [12:0] rpc;
  logic [7:0] rdata;
  logic [1:0] qtr;
  logic req;
  logic push;
  logic [12:0] sdata;
  logic load;
  logic [12:0] vec;
  logic sys;
  int num_errors = 0;
  int checks = 0;
  int n;
  always #5 clk = ~clk;
  // device and core model
  irq_logic u_irq_logic (.CLK_SYS_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .PORT_PINS_IN(pins), .PORT_READ_IN(prd),
    .EXT_PIN_IN(ext), .EXT_EDGE_RISING_IN(esel), .TIMER0_OVF_IN(t0), .PERIPH_ONE_EV_IN(ev1),
    .PERIPH_TWO_EV_IN(ev2), .RETURN_IRQ_IN(ret), .RETURN_PC_IN(rpc), .QUARTER_OUT(qtr),
    .IRQ_REQ_OUT(req), .STACK_PUSH_OUT(push), .STACK_DATA_OUT(sdata), .PC_LOAD_OUT(load),
    .PC_VECTOR_OUT(vec), .SYS_IRQ_OUT(sys));
  core_model u_core_model (.clk_in(clk), .nrst_in(nrst), .ret_cmd_in(ret_cmd), .push_in(push),
    .load_in(load), .push_data_in(sdata), .vector_in(vec), .ret_out(ret), .pc_out(rpc));
  // helpers: compare, wait, register write and read
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    tick(1);
    wr_s <= 1'b0;
    tick(1);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd_s <= 1'b1;
    tick(1);
    rd_s <= 1'b0;
    #1;
    cmp(rdata, e);
    tick(1);
  endtask
  task automatic conclude;
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // reset values
  task automatic t_reset;
    for (int i = 0; i < 5; i++) rdc(i[3:0], 8'h00);
  endtask
  // absent bits and dead offsets read zero
  task automatic t_absent;
    wr(4'h2, 8'hFF);
    wr(4'h4, 8'hFF);
    rdc(4'h2, `MASK_PERIPH_TWO);
    rdc(4'h4, `MASK_PERIPH_TWO);
    rdc(4'h8, 8'h00);
    rdc(4'hF, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h4, 8'h00);
  endtask
  // timer0 and the peripheral events set their flags with all enables off
  task automatic t_events;
    ev1 <= 8'hFF;
    ev2 <= 8'hFF;
    t0 <= 1'b1;
    tick(1);
    ev1 <= 8'h00;
    ev2 <= 8'h00;
    t0 <= 1'b0;
    tick(2);
    rdc(4'h1, 8'hFF);
    rdc(4'h2, 8'hF5);
    rdc(4'h0, 8'h04);
    cmp(req, 1'b0);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
  endtask
  // masked and watched port pins, then rising and falling edge modes on the external pin
  task automatic t_pins;
    wr(4'h5, 8'h01);
    pins <= 8'h02;
    tick(6);
    rdc(4'h0, 8'h00);
    pins <= 8'h03;
    tick(6);
    rdc(4'h0, 8'h01);
    prd <= 1'b1;
    tick(1);
    prd <= 1'b0;
    wr(4'h0, 8'h00);
    tick(4);
    rdc(4'h0, 8'h00);
    pins <= 8'h00;
    ext <= 1'b1;
    tick(8);
    rdc(4'h0, 8'h03);
    ext <= 1'b0;
    tick(4);
    prd <= 1'b1;
    tick(1);
    prd <= 1'b0;
    wr(4'h8, 8'h02);
    wr(4'h0, 8'h00);
    esel <= 1'b0;
    ext <= 1'b1;
    tick(8);
    rdc(4'h0, 8'h00);
    ext <= 1'b0;
    tick(8);
    rdc(4'h0, 8'h02);
    wr(4'h0, 8'h00);
    esel <= 1'b1;
  endtask
  // gated request, take, status interrupt, return
  task automatic t_take;
    wr(4'h3, 8'h01);
    wr(4'h7, 8'h01);
    wr(4'h0, 8'h80);
    ev1 <= 8'h01;
    tick(1);
    ev1 <= 8'h00;
    tick(8);
    cmp(req, 1'b0);
    wr(4'h0, 8'hC0);
    n = 0;
    while (load !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    cmp(n >= 9 && n <= 12, 1'b1);
    if (n == 20) conclude();
    cmp(vec, `VECTOR_ADDR);
    rdc(4'h0, 8'h40);
    rdc(4'h6, 8'h01);
    cmp(sys, 1'b1);
    wr(4'h7, 8'h00);
    tick(2);
    cmp(sys, 1'b0);
    wr(4'h7, 8'h01);
    wr(4'h8, 8'h01);
    tick(2);
    cmp(sys, 1'b0);
    wr(4'h1, 8'h00);
    ret_cmd <= 1'b1;
    tick(1);
    ret_cmd <= 1'b0;
    tick(3);
    rdc(4'h0, 8'hC0);
    cmp(req, 1'b0);
  endtask
  // main sequence
  initial begin
    tick(4);
    nrst <= 1'b1;
    tick(1);
    t_reset();
    t_absent();
    t_events();
    t_pins();
    t_take();
    conclude();
  end
  // cut a hang short
  initial begin
    tick(20000);
    num_errors++;
    conclude();
  end
endmodule
bind irq_logic irq_logic_monitor #(.PORT_W(PORT_W), .PC_W(PC_W)) u_irq_logic_monitor (
  .CLK_SYS_IN(CLK_SYS_IN), .NRST_IN(NRST_IN), .ADDR_IN(ADDR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .RETURN_PC_IN(RETURN_PC_IN), .QUARTER_OUT(QUARTER_OUT),
  .IRQ_REQ_OUT(IRQ_REQ_OUT), .STACK_PUSH_OUT(STACK_PUSH_OUT), .STACK_DATA_OUT(STACK_DATA_OUT),
  .PC_LOAD_OUT(PC_LOAD_OUT), .PC_VECTOR_OUT(PC_VECTOR_OUT));
